// [logic/svom_defines.svh]
// Register offsets, field positions, reset values and codes for the status output mapper
`ifndef SVOM_DEFINES_SVH
`define SVOM_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave
`define SVOM_OFF_CTRL 6'h00
`define SVOM_OFF_ZERO_SPEED 6'h04
`define SVOM_OFF_TARGET_SPEED 6'h08
`define SVOM_OFF_POS_WINDOW 6'h0c
`define SVOM_OFF_SLOT_FUNC 6'h10
`define SVOM_OFF_POLARITY 6'h14
`define SVOM_OFF_FLAGS 6'h18
`define SVOM_OFF_IRQ_STATUS 6'h1c
`define SVOM_OFF_IRQ_MASK 6'h20
`define SVOM_OFF_SLOT_OUT 6'h24

// Control register fields
`define SVOM_CTRL_MODE_LSB 0
`define SVOM_CTRL_LOAD_BIT 8

// Reset values
`define SVOM_RST_ZERO_SPEED 16'h000a
`define SVOM_RST_TARGET_SPEED 16'h03e8
`define SVOM_RST_POS_WINDOW 32'h0000_0063
`define SVOM_RST_POLARITY 5'h1f
`define SVOM_RST_MASK 6'h00

// Function codes carried by the output slots
`define SVOM_FC_NONE 4'h0
`define SVOM_FC_READY 4'h1
`define SVOM_FC_POWER 4'h2
`define SVOM_FC_ZERO 4'h3
`define SVOM_FC_TARGET 4'h4
`define SVOM_FC_POS 4'h5
`define SVOM_FC_TORQUE 4'h6

// Slot geometry
`define SVOM_SLOTS 5
`define SVOM_FC_W 4
`define SVOM_FLAGS 6

`endif

// [logic/svom_pkg.sv]
// Types and shared functions of the servo status output mapper
`default_nettype none
`include "svom_defines.svh"

package svom_pkg;

    // Control modes; the pure position modes are the first two of the position family
    typedef enum logic [2:0] {
        SVOM_MODE_SPEED,
        SVOM_MODE_TORQUE,
        SVOM_MODE_EXT_PULSE_POS,
        SVOM_MODE_INT_REG_POS,
        SVOM_MODE_EXT_PULSE_SPEED,
        SVOM_MODE_EXT_PULSE_TORQUE,
        SVOM_MODE_INT_REG_SPEED,
        SVOM_MODE_INT_REG_TORQUE
    } svom_mode_t;

    // Status flags; bit n-1 carries function code n
    typedef struct packed {
        logic torque_limited_flag;
        logic position_in_window_flag;
        logic target_speed_reached_flag;
        logic zero_speed_flag;
        logic control_power_on_flag;
        logic drive_ready_flag;
    } svom_flags_t;

    // Drive measurements sampled each control cycle
    typedef struct packed {
        logic drive_ready;
        logic fault_present;
        logic control_power;
        logic [15:0] motor_speed;
        logic [31:0] position_error;
        logic [31:0] motor_position;
        logic [31:0] target_position;
        logic torque_at_param_limit;
        logic torque_at_analog_limit;
    } svom_meas_t;

    // Magnitude of a signed 32-bit quantity
    function automatic logic [31:0] svom_abs32(input logic [31:0] v);
        svom_abs32 = v[31] ? 32'(-v) : v;
    endfunction : svom_abs32

    // Default slot functions per mode, slot 0 in the low nibble
    function automatic logic [19:0] svom_default_slots(input svom_mode_t m);
        if (m == SVOM_MODE_SPEED || m == SVOM_MODE_TORQUE) begin
            svom_default_slots = {`SVOM_FC_NONE, `SVOM_FC_NONE, `SVOM_FC_TARGET,
                                  `SVOM_FC_ZERO, `SVOM_FC_READY};
        end else begin
            svom_default_slots = {`SVOM_FC_NONE, `SVOM_FC_POS, `SVOM_FC_NONE,
                                  `SVOM_FC_ZERO, `SVOM_FC_READY};
        end
    endfunction : svom_default_slots

    // Position family test: external pulse side
    function automatic logic svom_is_ext_pos(input svom_mode_t m);
        svom_is_ext_pos = (m == SVOM_MODE_EXT_PULSE_POS) || (m == SVOM_MODE_EXT_PULSE_SPEED) ||
                          (m == SVOM_MODE_EXT_PULSE_TORQUE);
    endfunction : svom_is_ext_pos

    // Position family test: internal register side
    function automatic logic svom_is_int_pos(input svom_mode_t m);
        svom_is_int_pos = (m == SVOM_MODE_INT_REG_POS) || (m == SVOM_MODE_INT_REG_SPEED) ||
                          (m == SVOM_MODE_INT_REG_TORQUE);
    endfunction : svom_is_int_pos

endpackage : svom_pkg
`default_nettype wire

// [logic/svom_flag_eval.sv]
// Status flag comparators, registered once per control cycle
`timescale 1ns/1ps
`default_nettype none
`include "svom_defines.svh"

module svom_flag_eval
    import svom_pkg::*;
(
    // Clock and synchronised reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration
    input var svom_mode_t mode,
    input wire logic [15:0] zero_speed_range_param,
    input wire logic [15:0] target_speed_param,
    input wire logic [31:0] position_window_param,
    // Measurements and result
    input var svom_meas_t meas,
    output svom_flags_t flags
);

    svom_flags_t flags_d;
    logic [31:0] pt_err;
    logic [31:0] pr_err;

    // Comparisons on this cycle's measurements
    always_comb begin
        pt_err = svom_abs32(meas.position_error);
        pr_err = svom_abs32(32'(meas.motor_position - meas.target_position));
        flags_d.drive_ready_flag = meas.drive_ready & ~meas.fault_present;
        flags_d.control_power_on_flag = meas.control_power;
        flags_d.zero_speed_flag = (meas.motor_speed <= zero_speed_range_param);
        flags_d.target_speed_reached_flag = (meas.motor_speed >= target_speed_param) &&
            (mode != SVOM_MODE_EXT_PULSE_POS) && (mode != SVOM_MODE_INT_REG_POS);
        if (svom_is_ext_pos(mode)) begin
            flags_d.position_in_window_flag = (pt_err <= position_window_param);
        end else if (svom_is_int_pos(mode)) begin
            flags_d.position_in_window_flag = (pr_err <= position_window_param);
        end else begin
            flags_d.position_in_window_flag = 1'b0;
        end
        flags_d.torque_limited_flag = meas.torque_at_param_limit |
                                      meas.torque_at_analog_limit;
    end

    // Registered flags so every slot moves on the same edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= flags_d;
        end
    end

    ready_gated_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(meas.fault_present) |-> !flags.drive_ready_flag)
        else $error("drive ready set during fault");

    power_follows_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> flags.control_power_on_flag == $past(meas.control_power))
        else $error("control power flag missing");

    zero_speed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(meas.motor_speed) > $past(zero_speed_range_param) |-> !flags.zero_speed_flag)
        else $error("zero speed flag above range");

    target_pure_pos_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($past(mode) == SVOM_MODE_EXT_PULSE_POS || $past(mode) == SVOM_MODE_INT_REG_POS)
        |-> !flags.target_speed_reached_flag)
        else $error("target speed flag in pure position mode");

    torque_limit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        meas.torque_at_analog_limit |=> flags.torque_limited_flag)
        else $error("torque limit flag missed");

endmodule : svom_flag_eval
`default_nettype wire

// [logic/svom_slot_map.sv]
// Output slot function selection and polarity, registered
`timescale 1ns/1ps
`default_nettype none
`include "svom_defines.svh"

module svom_slot_map
    import svom_pkg::*;
(
    // Clock and synchronised reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Assignment and polarity
    input wire logic [19:0] slot_func,
    input wire logic [4:0] polarity,
    // Flags in, slot levels out
    input var svom_flags_t flags,
    output logic [4:0] slot_out
);

    logic [4:0] slot_d;

    // Pick each slot's flag by code, then apply its polarity
    always_comb begin
        for (int i = 0; i < `SVOM_SLOTS; i++) begin
            logic [3:0] code;
            logic act;
            code = slot_func[i*`SVOM_FC_W +: `SVOM_FC_W];
            act = 1'b0;
            if (code >= `SVOM_FC_READY && code <= `SVOM_FC_TORQUE) begin
                act = flags[3'(code - 4'h1)];
            end
            slot_d[i] = polarity[i] ? act : ~act;
        end
    end

    // Slot pins change only on the control clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_out <= '0;
        end else begin
            slot_out <= slot_d;
        end
    end

    slot0_polarity_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (slot_func[3:0] == `SVOM_FC_POWER && $stable(slot_func) && $stable(polarity))
        |=> slot_out[0] == ($past(polarity[0]) ~^ $past(flags.control_power_on_flag)))
        else $error("slot 0 polarity or routing wrong");

endmodule : svom_slot_map
`default_nettype wire

// [logic/svom_top.sv]
// Servo status output mapper: registers, interrupt and slot outputs
//
// Behaviour
// - Drive-ready (code 1) is on only when the drive is ready and no fault remains.
// - Control-power (code 2) follows control power regardless of faults and has no default slot.
// - Zero-speed (code 3) is on while motor speed is at or below the zero-speed range.
// - Target-speed (code 4) is on at or above target speed and never in the pure position modes.
// - In external-pulse position modes, position-in-window (code 5) is on when error <= window.
// - In internal-register position modes it is on within +/- window of target, default 99.
// - Torque-limited (code 6) is on when torque reaches the parameter or analog limit.
// - Software assigns any function to any output slot; the slot pins are fixed.
// - Default slot assignments are loaded according to the selected control mode.
// - Each slot has its own polarity bit so an active function can drive it on or off.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "svom_defines.svh"

module svom_top
    import svom_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Drive measurements
    input wire logic drive_ready_in,
    input wire logic fault_present_in,
    input wire logic control_power_in,
    input wire logic [15:0] motor_speed_in,
    input wire logic [31:0] position_error_in,
    input wire logic [31:0] motor_position_in,
    input wire logic [31:0] target_position_in,
    input wire logic torque_param_limit_in,
    input wire logic torque_analog_limit_in,
    // Connector slots and interrupt
    output logic [4:0] do_slot,
    output logic irq
);

    // Reset release through two flops; assertion stays asynchronous
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Register state
    svom_mode_t mode_q;
    logic [15:0] zero_speed_q;
    logic [15:0] target_speed_q;
    logic [31:0] pos_window_q;
    logic [19:0] slot_func_q;
    logic [4:0] polarity_q;
    logic [5:0] irq_status_q;
    logic [5:0] irq_mask_q;
    logic [5:0] flags_prev_q;
    logic ack_q;
    logic [31:0] readdata_q;

    svom_flags_t flags;
    svom_meas_t meas;
    logic [4:0] slot_out;

    // Byte-lane merge of a write into a 32-bit image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge

    // Bus handshake: every access waits exactly one cycle
    logic req;
    logic wr_take;
    logic rd_first;
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_take = avs_write & ack_q;
    assign rd_first = avs_read & ~ack_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Write data images for each register
    logic [31:0] wimg;
    logic [31:0] ctrl_img;
    always_comb begin
        ctrl_img = 32'h0;
        ctrl_img[`SVOM_CTRL_MODE_LSB +: 3] = mode_q;
        wimg = 32'h0;
        case (avs_address)
            `SVOM_OFF_CTRL: wimg = merge(ctrl_img, avs_writedata, avs_byteenable);
            `SVOM_OFF_ZERO_SPEED: wimg = merge({16'h0, zero_speed_q}, avs_writedata,
                                               avs_byteenable);
            `SVOM_OFF_TARGET_SPEED: wimg = merge({16'h0, target_speed_q}, avs_writedata,
                                                 avs_byteenable);
            `SVOM_OFF_POS_WINDOW: wimg = merge(pos_window_q, avs_writedata, avs_byteenable);
            `SVOM_OFF_SLOT_FUNC: wimg = merge({12'h0, slot_func_q}, avs_writedata,
                                              avs_byteenable);
            `SVOM_OFF_POLARITY: wimg = merge({27'h0, polarity_q}, avs_writedata,
                                             avs_byteenable);
            `SVOM_OFF_IRQ_MASK: wimg = merge({26'h0, irq_mask_q}, avs_writedata,
                                             avs_byteenable);
            `SVOM_OFF_IRQ_STATUS: wimg = merge(32'h0, avs_writedata, avs_byteenable);
            default: wimg = 32'h0;
        endcase
    end

    // Mode and thresholds
    logic ctrl_wr;
    logic load_req;
    svom_mode_t new_mode;
    assign ctrl_wr = wr_take && (avs_address == `SVOM_OFF_CTRL);
    assign new_mode = svom_mode_t'(wimg[`SVOM_CTRL_MODE_LSB +: 3]);
    assign load_req = ctrl_wr && (new_mode != mode_q || wimg[`SVOM_CTRL_LOAD_BIT]);

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= SVOM_MODE_SPEED;
            zero_speed_q <= `SVOM_RST_ZERO_SPEED;
            target_speed_q <= `SVOM_RST_TARGET_SPEED;
            pos_window_q <= `SVOM_RST_POS_WINDOW;
            polarity_q <= `SVOM_RST_POLARITY;
            irq_mask_q <= `SVOM_RST_MASK;
        end else if (wr_take) begin
            case (avs_address)
                `SVOM_OFF_CTRL: mode_q <= new_mode;
                `SVOM_OFF_ZERO_SPEED: zero_speed_q <= wimg[15:0];
                `SVOM_OFF_TARGET_SPEED: target_speed_q <= wimg[15:0];
                `SVOM_OFF_POS_WINDOW: pos_window_q <= wimg;
                `SVOM_OFF_POLARITY: polarity_q <= wimg[4:0];
                `SVOM_OFF_IRQ_MASK: irq_mask_q <= wimg[5:0];
                default: mode_q <= mode_q;
            endcase
        end
    end

    // Slot functions: defaults follow the mode, software may overwrite any slot
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            slot_func_q <= svom_default_slots(SVOM_MODE_SPEED);
        end else if (load_req) begin
            slot_func_q <= svom_default_slots(new_mode);
        end else if (wr_take && avs_address == `SVOM_OFF_SLOT_FUNC) begin
            slot_func_q <= wimg[19:0];
        end
    end

    // Measurements into the carrier struct
    always_comb begin
        meas.drive_ready = drive_ready_in;
        meas.fault_present = fault_present_in;
        meas.control_power = control_power_in;
        meas.motor_speed = motor_speed_in;
        meas.position_error = position_error_in;
        meas.motor_position = motor_position_in;
        meas.target_position = target_position_in;
        meas.torque_at_param_limit = torque_param_limit_in;
        meas.torque_at_analog_limit = torque_analog_limit_in;
    end

    svom_flag_eval u_flag_eval (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .mode(mode_q),
        .zero_speed_range_param(zero_speed_q),
        .target_speed_param(target_speed_q),
        .position_window_param(pos_window_q),
        .meas(meas),
        .flags(flags)
    );

    svom_slot_map u_slot_map (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .slot_func(slot_func_q),
        .polarity(polarity_q),
        .flags(flags),
        .slot_out(slot_out)
    );

    assign do_slot = slot_out;

    // Interrupt: any flag edge is an event; a new event beats a same-cycle clear
    logic [5:0] flag_edge;
    logic [5:0] clr_bits;
    assign flag_edge = flags ^ flags_prev_q;
    assign clr_bits = (wr_take && avs_address == `SVOM_OFF_IRQ_STATUS) ? wimg[5:0] : 6'h00;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flags_prev_q <= '0;
            irq_status_q <= '0;
        end else begin
            flags_prev_q <= flags;
            irq_status_q <= (irq_status_q & ~clr_bits) | flag_edge;
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // Read mux, captured in the waiting cycle so data stand when waitrequest falls
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            `SVOM_OFF_CTRL: rd_mux = ctrl_img;
            `SVOM_OFF_ZERO_SPEED: rd_mux = {16'h0, zero_speed_q};
            `SVOM_OFF_TARGET_SPEED: rd_mux = {16'h0, target_speed_q};
            `SVOM_OFF_POS_WINDOW: rd_mux = pos_window_q;
            `SVOM_OFF_SLOT_FUNC: rd_mux = {12'h0, slot_func_q};
            `SVOM_OFF_POLARITY: rd_mux = {27'h0, polarity_q};
            `SVOM_OFF_FLAGS: rd_mux = {26'h0, flags};
            `SVOM_OFF_IRQ_STATUS: rd_mux = {26'h0, irq_status_q};
            `SVOM_OFF_IRQ_MASK: rd_mux = {26'h0, irq_mask_q};
            `SVOM_OFF_SLOT_OUT: rd_mux = {27'h0, slot_out};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            readdata_q <= 32'h0;
        end else if (rd_first) begin
            readdata_q <= rd_mux;
        end
    end

    assign avs_readdata = readdata_q;

    bus_one_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        (req && !ack_q) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
        else $error("bus access did not finish after one wait");

    mode_defaults_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        (ctrl_wr && new_mode != mode_q) |=> slot_func_q == svom_default_slots(mode_q))
        else $error("defaults not loaded on mode change");

    slot_write_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        (wr_take && avs_address == `SVOM_OFF_SLOT_FUNC && avs_byteenable == 4'hf)
        |=> slot_func_q == $past(avs_writedata[19:0]))
        else $error("slot assignment write lost");

    event_beats_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        (flag_edge[0] && clr_bits[0]) |=> irq_status_q[0])
        else $error("flag event lost to clear");

    slot_registered_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        $stable(slot_func_q) && $stable(polarity_q) && $stable(flags) |=> $stable(do_slot))
        else $error("slot output moved without cause");

    default_window_a: assert property (@(posedge core_clk)
        $rose(rst_n_q) |-> pos_window_q == `SVOM_RST_POS_WINDOW && zero_speed_q == 16'h000a)
        else $error("reset thresholds wrong");

endmodule : svom_top
`default_nettype wire

// [tb/svom_ctrl_model.sv]
// Motion controller model that scans the connector status slots
`timescale 1ns/1ps
`default_nettype none

module svom_ctrl_model (
    // Clock
    input wire logic core_clk,
    // Connector slots in, last scanned value out
    input wire logic [4:0] do_slot,
    output logic [4:0] seen
);
    // One scan a cycle; a slower reader would only see later values
    always_ff @(posedge core_clk) begin
        seen <= do_slot;
    end
endmodule : svom_ctrl_model

`default_nettype wire

// [tb/svom_top_tb.sv]
// Self-checking bench for the servo status output mapper
`timescale 1ns/1ps
`default_nettype none
`include "svom_defines.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h, expected %h", $time, a, e); end end

module svom_top_tb;
    import svom_pkg::*;
    logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
    logic rdy, flt, pwr, tq_p, tq_a;
    logic [5:0] avs_address;
    logic [15:0] speed;
    logic [31:0] avs_writedata, avs_readdata, rd, pos_err, mot_pos, tgt_pos;
    logic [4:0] do_slot, seen;
    int n_fail, checks_done;
    int cycles = 0;

    svom_top dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .drive_ready_in(rdy), .fault_present_in(flt), .control_power_in(pwr),
        .motor_speed_in(speed), .position_error_in(pos_err), .motor_position_in(mot_pos),
        .target_position_in(tgt_pos), .torque_param_limit_in(tq_p),
        .torque_analog_limit_in(tq_a), .do_slot(do_slot), .irq(irq));

    svom_ctrl_model ctrl (.core_clk(core_clk), .do_slot(do_slot), .seen(seen));

    // Clock, 20 ns period
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Hang guard, well above the length of the run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            close_out;
        end
    end

    // One bus access; held until waitrequest is seen low, then one idle cycle
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk

    // New measurements, then time for flags and slots to settle
    task automatic meas(input logic [15:0] s, input logic [31:0] pe, input logic [31:0] mp);
        speed <= s;
        pos_err <= pe;
        mot_pos <= mp;
        repeat (3) @(posedge core_clk);
    endtask : meas

    task automatic t_regs;
        rchk(`SVOM_OFF_ZERO_SPEED, 32'h0000_000a);
        rchk(`SVOM_OFF_TARGET_SPEED, 32'h0000_03e8);
        rchk(`SVOM_OFF_POS_WINDOW, 32'h0000_0063);
        rchk(`SVOM_OFF_POLARITY, 32'h0000_001f);
        rchk(`SVOM_OFF_IRQ_MASK, 32'h0);
        rchk(`SVOM_OFF_SLOT_FUNC, 32'h0000_0431);
        wr(`SVOM_OFF_FLAGS, 32'hffff_ffff);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0007);
        rchk(6'h3c, 32'h0);
    endtask : t_regs

    task automatic t_flags;
        meas(16'd10, 32'h0, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0007);
        meas(16'd11, 32'h0, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0003);
        flt <= 1'b1;
        meas(16'd999, 32'h0, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0002);
        flt <= 1'b0;
        pwr <= 1'b0;
        meas(16'd1000, 32'h0, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0009);
        pwr <= 1'b1;
        tq_a <= 1'b1;
        meas(16'd1000, 32'h0, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_002b);
        tq_a <= 1'b0;
        tq_p <= 1'b1;
        meas(16'd1000, 32'h0, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_002b);
        tq_p <= 1'b0;
    endtask : t_flags

    task automatic t_pos;
        wr(`SVOM_OFF_CTRL, 32'h2);
        rchk(`SVOM_OFF_SLOT_FUNC, 32'h0000_5031);
        meas(16'd1000, 32'd99, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0013);
        meas(16'd1000, 32'd100, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0003);
        meas(16'd1000, 32'hffff_ff9d, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0013);
        wr(`SVOM_OFF_CTRL, 32'h3);
        tgt_pos <= 32'd1000;
        meas(16'd1000, 32'd500, 32'd901);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0013);
        meas(16'd1000, 32'h0, 32'd1100);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0003);
        rchk(`SVOM_OFF_CTRL, 32'h0000_0003);
        wr(`SVOM_OFF_CTRL, 32'h4);
        meas(16'd500, 32'd50, 32'h0);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_0013);
        wr(`SVOM_OFF_CTRL, 32'h6);
        meas(16'd1000, 32'd500, 32'd1000);
        rchk(`SVOM_OFF_FLAGS, 32'h0000_001b);
        wr(`SVOM_OFF_CTRL, 32'h0);
    endtask : t_pos

    // Mode 0 at 1000 r/min: ready, power and target speed are on
    task automatic t_slots;
        wr(`SVOM_OFF_SLOT_FUNC, 32'h0006_5432);
        meas(16'd1000, 32'h0, 32'h0);
        rchk(`SVOM_OFF_SLOT_OUT, 32'h0000_0005);
        `CHK(do_slot, 5'h05)
        wr(`SVOM_OFF_POLARITY, 32'h0000_0003);
        meas(16'd1000, 32'h0, 32'h0);
        `CHK(seen, 5'h19)
        wr(`SVOM_OFF_POLARITY, 32'h0000_001f);
        wr(`SVOM_OFF_CTRL, 32'h0000_0100);
        rchk(`SVOM_OFF_SLOT_FUNC, 32'h0000_0431);
    endtask : t_slots

    task automatic t_irq;
        wr(`SVOM_OFF_IRQ_STATUS, 32'h0000_003f);
        rchk(`SVOM_OFF_IRQ_STATUS, 32'h0);
        meas(16'd5, 32'h0, 32'h0);
        rchk(`SVOM_OFF_IRQ_STATUS, 32'h0000_000c);
        `CHK(irq, 1'b0)
        wr(`SVOM_OFF_IRQ_MASK, 32'h0000_0004);
        `CHK(irq, 1'b1)
        wr(`SVOM_OFF_IRQ_STATUS, 32'h0000_0004);
        `CHK(irq, 1'b0)
        // Ready falls in the cycle its clear lands; the new event must win
        flt <= 1'b1;
        wr(`SVOM_OFF_IRQ_STATUS, 32'h0000_0001);
        rchk(`SVOM_OFF_IRQ_STATUS, 32'h0000_0009);
        flt <= 1'b0;
    endtask : t_irq

    task automatic close_out;
        $display("Mismatches %0d, comparisons %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // Reset for five cycles, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {rdy, flt, pwr, tq_p, tq_a} = 5'b10100;
        {speed, pos_err, mot_pos, tgt_pos} = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs;
        t_flags;
        t_pos;
        t_slots;
        t_irq;
        close_out;
    end
endmodule : svom_top_tb

`default_nettype wire
